/* hdl/cmb_message_buffer.sv */
// message storage of a can controller: three tx buffers, five entry rx fifo, apb registers
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module cmb_message_buffer
    import cmb_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 arb_req,
    input  wire logic                 tx_done,
    input  wire logic                 tx_lost,
    input  wire logic                 tx_error,
    input  wire logic [15:0]          tx_stamp,
    output logic                      tx_go,
    output cmb_tx_frame_t             tx_frame,
    input  wire logic                 rx_byte_we,
    input  wire logic [3:0]           rx_byte_idx,
    input  wire logic [7:0]           rx_byte,
    input  wire logic                 rx_eof,
    input  wire cmb_rx_end_t          rx_end,
    output logic                      bus_ack_en,
    output logic                      tx_irq,
    output logic                      rx_irq,
    output logic                      ovr_irq
);

    // lowest priority value among candidates, lower index on a tie
    function automatic logic [2:0] cmb_pick(input logic [NUM_TX*BYTE_W-1:0] local_priority,
                                            input logic [NUM_TX-1:0] cand);
        logic       found;
        logic [1:0] best;
        logic [7:0] best_p;
        found  = 1'b0;
        best   = 2'd0;
        best_p = 8'hff;
        for (int i = 0; i < NUM_TX; i++) begin
            if (cand[i] && (!found || local_priority[i*BYTE_W +: BYTE_W] < best_p)) begin
                found  = 1'b1;
                best   = 2'(i);
                best_p = local_priority[i*BYTE_W +: BYTE_W];
            end
        end
        return {found, best};
    endfunction : cmb_pick

    function automatic logic [2:0] cmb_inc5(input logic [2:0] p);
        return (p == RX_PTR_LAST) ? 3'h0 : 3'(p + 3'h1);
    endfunction : cmb_inc5

    cmb_word_t             tx_mem [NUM_TX][BUF_WORDS];
    cmb_word_t             rx_fifo [RX_DEPTH][BUF_WORDS];
    cmb_word_t             rx_bg [BUF_WORDS];

    logic [NUM_TX-1:0]     tx_empty_ff;
    logic [NUM_TX-1:0]     tx_sel_ff;
    logic [NUM_TX-1:0]     abort_req_ff;
    logic [NUM_TX-1:0]     abort_ack_ff;
    logic [NUM_TX-1:0]     abort_stage_ff;
    logic [3:0]            ctrl_ff;
    logic                  busy_ff;
    logic [1:0]            act_ff;
    logic [2:0]            rx_cnt_ff;
    logic [2:0]            rx_rd_ff;
    logic [2:0]            rx_wr_ff;
    logic                  ovr_ff;
    logic [31:0]           prdata_ff;
    logic                  pready_ff;
    logic                  pslverr_ff;
    logic                  tx_go_ff;
    cmb_tx_frame_t         tx_frame_ff;
    logic                  bus_ack_en_ff;
    logic                  tx_irq_ff;
    logic                  rx_irq_ff;
    logic                  ovr_irq_ff;

    logic                  setup;
    logic                  wr_en;
    logic [7:0]            off;
    logic [3:0]            page;
    logic [1:0]            widx;
    logic [1:0]            sel_idx;
    logic                  win_ok;
    logic                  mapped;
    logic [31:0]           rd_data;
    logic [NUM_TX*BYTE_W-1:0] local_priority_vec;
    logic [2:0]            pick;
    logic                  start;
    logic [NUM_TX-1:0]     grant;
    logic [NUM_TX-1:0]     tx_set;
    logic [NUM_TX-1:0]     sw_ready;
    logic                  keep;
    logic                  push;
    logic                  drop;
    logic                  pop;
    logic                  wr_tx_flag;
    logic                  wr_tx_sel;
    logic                  wr_abort;
    logic                  wr_rx_flag;
    logic                  wr_ctrl;
    logic [NUM_TX-1:0]     sent;

    assign setup   = psel && !penable;
    assign wr_en   = psel && penable && pwrite && pready_ff && !pslverr_ff;
    assign off     = {paddr[7:2], 2'b00};
    assign page    = paddr[7:4];
    assign widx    = paddr[3:2];
    assign sel_idx = tx_sel_ff[1] ? 2'd1 : (tx_sel_ff[2] ? 2'd2 : 2'd0);
    assign win_ok  = |(tx_sel_ff & tx_empty_ff);

    // register write strobes, taken at the end of the access cycle
    assign wr_tx_flag = wr_en && off == OFF_TX_FLAG;
    assign wr_tx_sel  = wr_en && off == OFF_TX_SELECT;
    assign wr_abort   = wr_en && off == OFF_ABORT_REQ;
    assign wr_rx_flag = wr_en && off == OFF_RX_FLAG;
    assign wr_ctrl    = wr_en && off == OFF_CTRL;

    always_comb begin
        for (int i = 0; i < NUM_TX; i++) begin
            local_priority_vec[i*BYTE_W +: BYTE_W] = tx_mem[i][BUF_WORDS-1][LOCAL_PRIORITY_LSB +: BYTE_W];
        end
    end

    // candidates: pending, not being aborted
    assign pick  = cmb_pick(local_priority_vec, ~tx_empty_ff & ~abort_stage_ff);
    assign start = arb_req && !busy_ff && pick[2];

    // grant aborts except on the frame on the bus or just chosen
    always_comb begin
        for (int i = 0; i < NUM_TX; i++) begin
            grant[i] = abort_req_ff[i] && !tx_empty_ff[i] && !abort_stage_ff[i]
                    && !(busy_ff && act_ff == 2'(i))
                    && !(start && pick[1:0] == 2'(i));
            sent[i] = busy_ff && tx_done && act_ff == 2'(i);
            tx_set[i] = abort_stage_ff[i] || sent[i];
            sw_ready[i] = wr_tx_flag && pwdata[i] && tx_empty_ff[i];
        end
    end

    // apb read mux
    always_comb begin
        rd_data = 32'h0;
        mapped  = 1'b1;
        if (off == OFF_TX_FLAG) begin
            rd_data[NUM_TX-1:0] = tx_empty_ff;
        end else if (off == OFF_TX_SELECT) begin
            rd_data[NUM_TX-1:0] = tx_sel_ff;
        end else if (off == OFF_ABORT_REQ) begin
            rd_data[NUM_TX-1:0] = abort_req_ff;
        end else if (off == OFF_ABORT_ACK) begin
            rd_data[NUM_TX-1:0] = abort_ack_ff;
        end else if (off == OFF_RX_FLAG) begin
            rd_data[RXF_FULL]    = rx_cnt_ff != 3'h0;
            rd_data[RXF_OVERRUN] = ovr_ff;
        end else if (off == OFF_CTRL) begin
            rd_data[3:0] = ctrl_ff;
        end else if (page == TX_WIN_PAGE) begin
            rd_data = win_ok ? tx_mem[sel_idx][widx] : 32'h0;
        end else if (page == RX_WIN_PAGE) begin
            rd_data = (rx_cnt_ff != 3'h0) ? rx_fifo[rx_rd_ff][widx] : 32'h0;
        end else begin
            mapped = 1'b0;
        end
    end

    // bus slave: data latched in setup, one access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h0;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup && !mapped;
            if (setup && !pwrite) begin
                prdata_ff <= rd_data;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_ff <= pwdata[3:0];
        end
    end

    // select: lowest written bit that is also empty
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_sel_ff <= '0;
        end else if (wr_tx_sel) begin
            tx_sel_ff <= (pwdata[NUM_TX-1:0] & tx_empty_ff)
                       & ~((pwdata[NUM_TX-1:0] & tx_empty_ff) - 3'h1);
        end
    end

    // empty flags: hardware set wins over software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_empty_ff <= TX_EMPTY_RST;
        end else begin
            tx_empty_ff <= (tx_empty_ff & ~sw_ready) | tx_set;
        end
    end

    // abort request, acknowledge, then release a cycle later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abort_req_ff   <= '0;
            abort_ack_ff   <= '0;
            abort_stage_ff <= '0;
        end else begin
            abort_stage_ff <= grant;
            for (int i = 0; i < NUM_TX; i++) begin
                if (tx_set[i]) begin
                    abort_req_ff[i] <= 1'b0;
                end else if (wr_abort && pwdata[i] && !tx_empty_ff[i]) begin
                    abort_req_ff[i] <= 1'b1;
                end
                if (grant[i]) begin
                    abort_ack_ff[i] <= 1'b1;
                end else if (sw_ready[i] || sent[i]) begin
                    abort_ack_ff[i] <= 1'b0;
                end
            end
        end
    end

    // transmit scheduling toward the bit engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_ff     <= 1'b0;
            act_ff      <= 2'd0;
            tx_go_ff    <= 1'b0;
            tx_frame_ff <= '0;
        end else begin
            tx_go_ff <= start;
            if (start) begin
                busy_ff     <= 1'b1;
                act_ff      <= pick[1:0];
                tx_frame_ff <= {pick[1:0], tx_mem[pick[1:0]][3][BYTE_W-1:0],
                                tx_mem[pick[1:0]][2], tx_mem[pick[1:0]][1],
                                tx_mem[pick[1:0]][0]};
            end else if (tx_done || tx_lost || tx_error) begin
                busy_ff <= 1'b0;
            end
        end
    end

    // buffer storage: software window and stamp on success
    // not reset: software loads a buffer before marking it pending
    always_ff @(posedge pclk) begin
        if (wr_en && page == TX_WIN_PAGE && win_ok) begin
            if (widx == 2'd3) begin
                tx_mem[sel_idx][widx][STAMP_LSB-1:0] <= pwdata[STAMP_LSB-1:0];
            end else begin
                tx_mem[sel_idx][widx] <= pwdata;
            end
        end
        if (busy_ff && tx_done) begin
            tx_mem[act_ff][BUF_WORDS-1][31:STAMP_LSB] <= tx_stamp;
        end
    end

    // background buffer filled byte by byte during the frame
    always_ff @(posedge pclk) begin
        if (rx_byte_we) begin
            rx_bg[rx_byte_idx[3:2]][rx_byte_idx[1:0]*BYTE_W +: BYTE_W] <= rx_byte;
        end
        if (push) begin
            rx_fifo[rx_wr_ff] <= rx_bg;
        end
    end

    assign keep = rx_eof && rx_end.valid && rx_end.accept
               && (!rx_end.own || ctrl_ff[CTRL_LOOPBACK]);
    assign push = keep && rx_cnt_ff != RX_CNT_FULL;
    assign drop = keep && rx_cnt_ff == RX_CNT_FULL;
    // pop only when something is queued, so an idle clear cannot underflow
    assign pop  = wr_rx_flag && pwdata[RXF_FULL] && rx_cnt_ff != 3'h0;

    // push and pop in one cycle leave the occupancy unchanged

    // fifo pointers and occupancy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_cnt_ff <= 3'h0;
            rx_rd_ff  <= 3'h0;
            rx_wr_ff  <= 3'h0;
        end else begin
            if (push) begin
                rx_wr_ff <= cmb_inc5(rx_wr_ff);
            end
            if (pop) begin
                rx_rd_ff <= cmb_inc5(rx_rd_ff);
            end
            if (push && !pop) begin
                rx_cnt_ff <= 3'(rx_cnt_ff + 3'h1);
            end else if (pop && !push) begin
                rx_cnt_ff <= 3'(rx_cnt_ff - 3'h1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovr_ff <= 1'b0;
        end else if (drop) begin
            ovr_ff <= 1'b1;
        end else if (wr_rx_flag && pwdata[RXF_OVERRUN]) begin
            ovr_ff <= 1'b0;
        end
    end

    // event outputs and acknowledge enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_irq_ff     <= 1'b0;
            rx_irq_ff     <= 1'b0;
            ovr_irq_ff    <= 1'b0;
            bus_ack_en_ff <= 1'b1;
        end else begin
            tx_irq_ff     <= ctrl_ff[CTRL_TX_IE] && |(tx_empty_ff & ~tx_sel_ff);
            rx_irq_ff     <= ctrl_ff[CTRL_RX_IE] && rx_cnt_ff != 3'h0;
            ovr_irq_ff    <= ctrl_ff[CTRL_OVR_IE] && ovr_ff;
            bus_ack_en_ff <= ctrl_ff[CTRL_LOOPBACK] || !busy_ff;
        end
    end

    assign prdata     = prdata_ff;
    assign pready     = pready_ff;
    assign pslverr    = pslverr_ff;
    assign tx_go      = tx_go_ff;
    assign tx_frame   = tx_frame_ff;
    assign bus_ack_en = bus_ack_en_ff;
    assign tx_irq     = tx_irq_ff;
    assign rx_irq     = rx_irq_ff;
    assign ovr_irq    = ovr_irq_ff;

endmodule : cmb_message_buffer
`default_nettype wire

/* include/cmb_pkg.sv */
// constants and carrier types of the can message buffer manager
package cmb_pkg;
    localparam int NUM_TX    = 3;
    localparam int RX_DEPTH  = 5;
    localparam int BUF_WORDS = 4;
    localparam int BYTE_W    = 8;
    localparam int MSG_BITS  = 104;
    localparam int LOCAL_PRIORITY_LSB  = 8;
    localparam int STAMP_LSB = 16;

    localparam logic [7:0] OFF_TX_FLAG   = 8'h00;
    localparam logic [7:0] OFF_TX_SELECT = 8'h04;
    localparam logic [7:0] OFF_ABORT_REQ = 8'h08;
    localparam logic [7:0] OFF_ABORT_ACK = 8'h0c;
    localparam logic [7:0] OFF_RX_FLAG   = 8'h10;
    localparam logic [7:0] OFF_CTRL      = 8'h14;
    localparam logic [3:0] TX_WIN_PAGE   = 4'h4;
    localparam logic [3:0] RX_WIN_PAGE   = 4'h8;

    localparam int CTRL_LOOPBACK = 0;
    localparam int CTRL_TX_IE    = 1;
    localparam int CTRL_RX_IE    = 2;
    localparam int CTRL_OVR_IE   = 3;
    localparam int RXF_FULL      = 0;
    localparam int RXF_OVERRUN   = 1;

    localparam logic [2:0] TX_EMPTY_RST = 3'h7;
    localparam logic [3:0] CTRL_RST     = 4'h0;
    localparam logic [2:0] RX_CNT_FULL  = 3'h5;
    localparam logic [2:0] RX_PTR_LAST  = 3'h4;

    typedef logic [31:0] cmb_word_t;

    typedef struct packed {
        logic [1:0]          idx;
        logic [MSG_BITS-1:0] msg;
    } cmb_tx_frame_t;

    typedef struct packed {
        logic valid;
        logic accept;
        logic own;
    } cmb_rx_end_t;
endpackage : cmb_pkg

/* tb/cmb_can_engine.sv */
// protocol engine model on the far side of the buffers
`timescale 1ns/1ps
`default_nettype none
module cmb_can_engine
    import cmb_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          tx_go,
    input  wire cmb_tx_frame_t tx_frame,
    output var logic           arb_req,
    output var logic           tx_done,
    output var logic           tx_lost,
    output var logic           tx_error,
    output var logic [15:0]    tx_stamp,
    output var logic           rx_byte_we,
    output var logic [3:0]     rx_byte_idx,
    output var logic [7:0]     rx_byte,
    output var logic           rx_eof,
    output var cmb_rx_end_t    rx_end
);
    initial begin
        {arb_req, tx_done, tx_lost, tx_error, rx_byte_we, rx_eof} = 6'h00;
        tx_stamp = 16'h0000;
        rx_byte_idx = 4'h0;
        rx_byte = 8'h00;
        rx_end = 3'h0;
    end
    // ask for a frame; index 3 means nothing was handed over
    task automatic arb(output logic [1:0] ix, output cmb_word_t m);
        ix = 2'h3;
        m = 32'h0;
        @(posedge pclk);
        arb_req <= 1'b1;
        @(posedge pclk);
        arb_req <= 1'b0;
        for (int n = 0; n < 4; n++) begin
            @(posedge pclk);
            if (tx_go === 1'b1) begin
                ix = tx_frame.idx;
                m = tx_frame.msg[31:0];
            end
        end
    endtask : arb
    // end the frame: 0 sent, 1 lost, 2 error
    task automatic fin(input int k, input logic [15:0] s);
        @(posedge pclk);
        tx_done <= (k == 0);
        tx_lost <= (k == 1);
        tx_error <= (k == 2);
        tx_stamp <= s;
        @(posedge pclk);
        {tx_done, tx_lost, tx_error} <= 3'h0;
        tx_stamp <= ~s;
    endtask : fin
    task automatic frame(input logic [7:0] b, input cmb_rx_end_t e);
        for (int n = 0; n < 15; n++) begin
            @(posedge pclk);
            rx_byte_we <= 1'b1;
            rx_byte_idx <= 4'(n);
            rx_byte <= b + 8'(n);
        end
        @(posedge pclk);
        rx_byte_we <= 1'b0;
        rx_byte <= ~rx_byte;
        rx_eof <= 1'b1;
        rx_end <= e;
        @(posedge pclk);
        rx_eof <= 1'b0;
        rx_end <= 3'h0;
    endtask : frame
endmodule : cmb_can_engine
`default_nettype wire

/* tb/cmb_message_buffer_asserts.sv */
// port checker of the can message buffer
`timescale 1ns/1ps
`default_nettype none
module cmb_asserts
    import cmb_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        arb_req,
    input wire logic        tx_done,
    input wire logic        tx_lost,
    input wire logic        tx_error,
    input wire logic        tx_go,
    input wire logic        rx_eof,
    input wire cmb_rx_end_t rx_end,
    input wire logic        tx_irq,
    input wire logic        rx_irq,
    input wire logic        ovr_irq
);
    logic [3:0] ctrl_ff;
    logic       act_ff;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // shadow of the control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ctrl_ff <= 4'h0;
        else if (psel && penable && pready && pwrite && paddr == OFF_CTRL) ctrl_ff <= pwdata[3:0];
    end
    // a frame is on the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) act_ff <= 1'b0;
        else if (tx_go) act_ff <= 1'b1;
        else if (tx_done || tx_lost || tx_error) act_ff <= 1'b0;
    end
    sequence s_hit;
        rx_eof && rx_end.valid && rx_end.accept;
    endsequence
    sequence s_push;
        s_hit ##0 (!rx_end.own || ctrl_ff[0]) && ctrl_ff[2];
    endsequence
    sequence s_own;
        s_hit ##0 rx_end.own && !ctrl_ff[0] && ctrl_ff[2] && !rx_irq;
    endsequence
    a_go_after_arb: assert property (tx_go |-> $past(arb_req))
        else $error("frame handed over without request");
    a_go_when_idle: assert property (tx_go |-> !act_ff)
        else $error("frame handed over during transmission");
    a_go_single: assert property (tx_go |=> !tx_go)
        else $error("handover longer than one cycle");
    a_push_irq: assert property (s_push |-> ##2 rx_irq)
        else $error("stored frame without receive interrupt");
    a_own_skip: assert property (s_own |-> ##2 !rx_irq)
        else $error("own frame was stored");
    a_reject_skip: assert property ((rx_eof && !(rx_end.valid && rx_end.accept) && ctrl_ff[2]
        && !rx_irq) |-> ##2 !rx_irq)
        else $error("rejected frame was stored");
    a_ovr_cause: assert property ($rose(ovr_irq) |-> $past(rx_eof) || $past(rx_eof, 2))
        else $error("overrun without incoming frame");
    a_sent_irq: assert property ((tx_done && act_ff && ctrl_ff[1]) |-> ##2 tx_irq)
        else $error("no transmit interrupt after send");
endmodule : cmb_asserts
bind cmb_message_buffer cmb_asserts chk_u (.*);
`default_nettype wire

/* tb/cmb_message_buffer_tb_top.sv */
// self-checking bench of the can message buffer
`timescale 1ns/1ps
`default_nettype none
module cmb_message_buffer_tb_top
    import cmb_pkg::*;
;
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic          arb_req, tx_done, tx_lost, tx_error, tx_go, rx_byte_we, rx_eof;
    logic          bus_ack_en, tx_irq, rx_irq, ovr_irq;
    logic [7:0]    paddr, rx_byte;
    logic [15:0]   tx_stamp;
    logic [3:0]    rx_byte_idx;
    logic [1:0]    id;
    cmb_word_t     pwdata, prdata, q, w0;
    cmb_tx_frame_t tx_frame;
    cmb_rx_end_t   rx_end;
    int            num_errors, tests_run;
    logic [7:0]    pr [3] = '{8'h05, 8'h02, 8'h02};

    cmb_message_buffer dut_u (.*);
    cmb_can_engine eng_u (.*);

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic apb(input logic w, input logic [7:0] a, input cmb_word_t d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) num_errors++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input string s, input logic [31:0] v, input logic [31:0] x);
        tests_run++;
        if (v !== x) begin
            num_errors++;
            $display("FAIL %s exp %h seen %h", s, x, v);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop
    // the tests need some 400 cycles
    initial begin
        #200000;
        num_errors++;
        report_and_stop;
    end
    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, OFF_TX_FLAG, 0); chk("tx_flag", q, 32'h7);
        apb(0, 8'hfc, 0); chk("slverr", e, 1);
        apb(1, OFF_CTRL, 32'he);
        for (int i = 0; i < 3; i++) begin
            apb(1, OFF_TX_SELECT, 32'h1 << i);
            apb(1, 8'h40, 32'ha0 + i);
            apb(1, 8'h4c, {16'h0, pr[i], 8'h0});
            apb(0, 8'h4c, 0); chk("local_priority", q[15:8], pr[i]);
        end
        apb(1, OFF_TX_SELECT, 0);
        apb(1, OFF_TX_FLAG, 32'h7);
        apb(0, OFF_TX_FLAG, 0); chk("pending", q, 0);
        chk("tx_irq_idle", tx_irq, 0);
        // lost, then error, then sent
        for (int i = 0; i < 3; i++) begin
            eng_u.arb(id, w0); chk("pick", id, 1);
            chk("msg", w0, 32'ha1);
            chk("ack_off", bus_ack_en, 0);
            eng_u.fin((i + 1) % 3, 16'h1234);
        end
        apb(0, OFF_TX_FLAG, 0); chk("sent", q, 32'h2);
        chk("tx_irq", tx_irq, 1);
        apb(0, OFF_ABORT_ACK, 0); chk("ack", q, 0);
        apb(1, OFF_TX_SELECT, 32'h2);
        apb(0, 8'h4c, 0); chk("stamp", q[31:16], 16'h1234);
        apb(1, OFF_TX_SELECT, 0);
        eng_u.arb(id, w0); chk("next", id, 2);
        apb(1, OFF_ABORT_REQ, 32'h5);
        apb(0, OFF_ABORT_ACK, 0); chk("abort_ack", q, 1);
        apb(0, OFF_TX_FLAG, 0); chk("released", q, 3);
        eng_u.fin(0, 16'h0);
        apb(0, OFF_ABORT_ACK, 0); chk("sent_ack", q, 1);
        apb(0, OFF_ABORT_REQ, 0); chk("req_clr", q, 0);
        chk("ack_on", bus_ack_en, 1);
        eng_u.arb(id, w0); chk("idle", id, 3);
        eng_u.frame(8'h10, 3'b111);
        eng_u.frame(8'h20, 3'b010);
        eng_u.frame(8'h30, 3'b100);
        apb(0, OFF_RX_FLAG, 0); chk("no_store", q, 0);
        for (int k = 0; k < 6; k++) eng_u.frame(8'h40 + 8'(k * 16), 3'b110);
        apb(0, OFF_RX_FLAG, 0); chk("overrun", q, 3);
        chk("ovr_irq", ovr_irq, 1);
        apb(1, OFF_TX_FLAG, 32'h1);
        eng_u.arb(id, w0); chk("tx_full", id, 0);
        eng_u.fin(0, 16'h0);
        for (int k = 0; k < 5; k++) begin
            logic [7:0] b;
            b = 8'h40 + 8'(k * 16);
            apb(0, 8'h80, 0); chk("fg", q, {b + 8'h3, b + 8'h2, b + 8'h1, b});
            apb(1, OFF_RX_FLAG, 32'h1);
        end
        apb(0, OFF_RX_FLAG, 0); chk("drained", q, 2);
        chk("rx_irq_off", rx_irq, 0);
        apb(1, OFF_RX_FLAG, 32'h2);
        apb(1, OFF_CTRL, 32'hf);
        eng_u.frame(8'hc0, 3'b111);
        apb(0, OFF_RX_FLAG, 0); chk("loop", q, 1);
        chk("rx_irq", rx_irq, 1);
        apb(0, 8'h8c, 0); chk("fg_w3", q[23:0], 24'hcecdcc);
        report_and_stop;
    end
endmodule : cmb_message_buffer_tb_top
`default_nettype wire
